// ===== hdl/spbc_bit_divider.v
// spbc_bit_divider.v - internal bit clock divider with prescaler and modulus
`timescale 1ns/1ps
`default_nettype none
`include "spbc_regs.vh"

module spbc_bit_divider (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       src_tick_i,
   input  wire       psr_i,
   input  wire [7:0] pm_i,
   output reg        bclk_o,
   output reg        rise_o,
   output reg        fall_o
);

   reg [2:0] pre;
   reg [7:0] cnt;
   wire      pre_done = psr_i | (pre == `SPBC_PRESCALE - 4'h1);

   // ------------------------------------------------------------------------
   // source / 2 / prescale / (pm+1): one toggle per prescaled pm+1 ticks
   // ------------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         pre    <= 3'h0;
         cnt    <= 8'h00;
         bclk_o <= 1'b0;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         rise_o <= 1'b0;
         fall_o <= 1'b0;
         if (src_tick_i) begin
            pre <= pre_done ? 3'h0 : pre + 3'h1;
            if (pre_done) begin
               if (cnt >= pm_i) begin
                  cnt    <= 8'h00;
                  bclk_o <= ~bclk_o;
                  rise_o <= ~bclk_o;
                  fall_o <= bclk_o;
               end else begin
                  cnt <= cnt + 8'h01;
               end
            end
         end
      end
   end

endmodule // spbc_bit_divider

`default_nettype wire

// ===== hdl/spbc_rate_mult.v
// spbc_rate_mult.v - fractional rate multiplier giving 512 pulses per 525 clocks
`timescale 1ns/1ps
`default_nettype none
`include "spbc_regs.vh"

module spbc_rate_mult (
   input  wire clk_i,
   input  wire rst_i,
   output reg  tick_o
);

   reg  [9:0] acc;
   wire [10:0] sum = {1'b0, acc} + {1'b0, `SPBC_MUL_NUM};

   // ------------------------------------------------------------------------
   // accumulator
   // ------------------------------------------------------------------------
   // the enable stream is jittery by one cycle; good enough for codec clocks
   always @(posedge clk_i) begin
      if (rst_i) begin
         acc    <= 10'h000;
         tick_o <= 1'b0;
      end else if (sum >= {1'b0, `SPBC_MUL_DEN}) begin
         acc    <= sum[9:0] - `SPBC_MUL_DEN;
         tick_o <= 1'b1;
      end else begin
         acc    <= sum[9:0];
         tick_o <= 1'b0;
      end
   end

endmodule // spbc_rate_mult

`default_nettype wire

// ===== hdl/spbc_regs.vh
// spbc_regs.vh - register map, field positions and constants of the serial port clock block
`ifndef SPBC_REGS_VH
`define SPBC_REGS_VH

// ----------------------------------------------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SPBC_AUDIO_CONTROL_A     8'h00
`define SPBC_AUDIO_CONTROL_C     8'h04
`define SPBC_BASEBAND_CONTROL_A  8'h08
`define SPBC_BASEBAND_CONTROL_C  8'h0c
`define SPBC_AUDIO_GPIO_OUT      8'h10
`define SPBC_BASEBAND_GPIO_OUT   8'h14
`define SPBC_STATUS              8'h18

// ----------------------------------------------------------------------------
// control a fields
// ----------------------------------------------------------------------------
`define SPBC_CA_PM_LSB    0
`define SPBC_CA_PM_MSB    7
`define SPBC_CA_PSR       8
`define SPBC_CA_WL_LSB    9
`define SPBC_CA_WL_MSB    10
`define SPBC_CA_DC_LSB    11
`define SPBC_CA_DC_MSB    15
`define SPBC_CA_WIDTH     16

// ----------------------------------------------------------------------------
// control c fields
// ----------------------------------------------------------------------------
`define SPBC_CC_SCD_LSB   0
`define SPBC_CC_SCD_MSB   2
`define SPBC_CC_CLOCK_PIN_DIRECTION      3
`define SPBC_CC_SYN       4
`define SPBC_CC_CKP       5
`define SPBC_CC_MUL       6
`define SPBC_CC_MOD       7
`define SPBC_CC_WIDTH     8

// ----------------------------------------------------------------------------
// gpio out register: low 6 = value, next 6 = pin enable as gpio output
// pin order: 0 ctrl0, 1 ctrl1, 2 ctrl2, 3 clock, 4 rx data, 5 tx data
// ----------------------------------------------------------------------------
`define SPBC_GP_WIDTH     12
`define SPBC_PINS         6

// ----------------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------------
`define SPBC_CA_RESET     16'h0000
`define SPBC_CC_RESET     8'h00
`define SPBC_GP_RESET     12'h000
`define SPBC_WL_8         2'h0
`define SPBC_WL_12        2'h1
`define SPBC_WL_16        2'h2
`define SPBC_PRESCALE     4'h8
`define SPBC_MUL_NUM      10'h200
`define SPBC_MUL_DEN      10'h20d

`endif

// ===== hdl/spbc_top.v
// spbc_top.v - clock and pin control for the audio and baseband serial ports
//
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "spbc_regs.vh"

// How it works
// R01 - transmit and receive run apart or share one clock and frame sync
// R02 - async: ctrl0 rx clock, ctrl1 rx sync, ctrl2 tx sync, clock pin tx
// R03 - sync: ctrl0/1 are flags, ctrl2 shared frame sync, clock pin shared
// R04 - three-bit ctrl direction field plus clock pin direction bit set pins
// R05 - pins unused by the serial function can be gpio in or out
// R06 - clock pin is input for external clock, output for internal
// R07 - baseband uses system clock; audio picks system or multiplier clock
// R08 - async: clock dir 1 internal tx clock, ctrl0 dir 1 internal rx
// R09 - sync: ctrl0 dir ignored; clock dir selects both clocks
// R10 - external bit clock at most a third of the system clock
// R11 - bit clock = source / (2 * (8 or 1) * (modulus + 1))
// R12 - software never sets bypass with modulus zero
// R13 - polarity clear: drive on tx rising, sample on rx falling
// R14 - polarity set: drive on tx falling, sample on rx falling
// R15 - audio multiplier scales system clock by 512/525
// R16 - software picks multiplier, bypass and modulus 3 for codec rate
// R17 - word length programmable to 8, 12 or 16 bits
// R18 - one slot per frame or up to 32 slots per frame
// R19 - external clocks and syncs are synchronised with edge detection
module spbc_top #(
   parameter AW = 8
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          cyc_i,
   input  wire          stb_i,
   input  wire          we_i,
   input  wire [AW-1:0] adr_i,
   input  wire [3:0]    sel_i,
   input  wire [31:0]   dat_i,
   output reg  [31:0]   dat_o,
   output reg           ack_o,
   input  wire [5:0]    audio_pins_i,
   output reg  [5:0]    audio_pins_o,
   output reg  [5:0]    audio_pins_oe_n_o,
   input  wire [5:0]    baseband_pins_i,
   output reg  [5:0]    baseband_pins_o,
   output reg  [5:0]    baseband_pins_oe_n_o,
   output reg  [1:0]    tx_drive_o,
   output reg  [1:0]    rx_sample_o,
   output reg  [1:0]    tx_sync_edge_o,
   output reg  [1:0]    rx_sync_edge_o,
   output reg  [9:0]    frame_bits_o
);

   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   reg [`SPBC_CA_WIDTH-1:0] audio_control_a;
   reg [`SPBC_CC_WIDTH-1:0] audio_control_c;
   reg [`SPBC_CA_WIDTH-1:0] baseband_control_a;
   reg [`SPBC_CC_WIDTH-1:0] baseband_control_c;
   reg [`SPBC_GP_WIDTH-1:0] audio_gpio;
   reg [`SPBC_GP_WIDTH-1:0] baseband_gpio;

   // pin synchronisers, first stage read only by the second
   reg [5:0] a_s1;
   reg [5:0] a_s2;
   reg [5:0] a_s3;
   reg [5:0] b_s1;
   reg [5:0] b_s2;
   reg [5:0] b_s3;

   wire mul_tick;
   wire a_bclk;
   wire a_rise;
   wire a_fall;
   wire b_bclk;
   wire b_rise;
   wire b_fall;

   // word length code to bits
   function [4:0] spbc_wl_bits;
      input [1:0] code;
      begin
         case (code)
            `SPBC_WL_12: spbc_wl_bits = 5'd12;
            `SPBC_WL_16: spbc_wl_bits = 5'd16;
            default:     spbc_wl_bits = 5'd8;
         endcase
      end
   endfunction

   // drive edge from polarity: clear -> rising, set -> falling
   function spbc_drive_edge;
      input clock_edge_polarity;
      input rise;
      input fall;
      begin
         spbc_drive_edge = clock_edge_polarity ? fall : rise;
      end
   endfunction

   // ------------------------------------------------------------------------
   // clock sources
   // ------------------------------------------------------------------------
   // R15 multiplier tick
   spbc_rate_mult u_mult (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .tick_o (mul_tick)
   );

   // R07 audio picks multiplier or system clock, baseband system only
   // R11 divider per port
   spbc_bit_divider u_adiv (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .src_tick_i (audio_control_c[`SPBC_CC_MUL] ? mul_tick : 1'b1),
      .psr_i      (audio_control_a[`SPBC_CA_PSR]),
      .pm_i       (audio_control_a[`SPBC_CA_PM_MSB:`SPBC_CA_PM_LSB]),
      .bclk_o     (a_bclk),
      .rise_o     (a_rise),
      .fall_o     (a_fall)
   );

   spbc_bit_divider u_bdiv (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .src_tick_i (1'b1),
      .psr_i      (baseband_control_a[`SPBC_CA_PSR]),
      .pm_i       (baseband_control_a[`SPBC_CA_PM_MSB:`SPBC_CA_PM_LSB]),
      .bclk_o     (b_bclk),
      .rise_o     (b_rise),
      .fall_o     (b_fall)
   );

   // ------------------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------------------
   // R19 two-flop sync then a history flop for edges
   always @(posedge clk_i) begin
      if (rst_i) begin
         a_s1 <= 6'h00;
         a_s2 <= 6'h00;
         a_s3 <= 6'h00;
         b_s1 <= 6'h00;
         b_s2 <= 6'h00;
         b_s3 <= 6'h00;
      end else begin
         a_s1 <= audio_pins_i;
         a_s2 <= a_s1;
         a_s3 <= a_s2;
         b_s1 <= baseband_pins_i;
         b_s2 <= b_s1;
         b_s3 <= b_s2;
      end
   end

   // ------------------------------------------------------------------------
   // per-port clock routing
   // ------------------------------------------------------------------------
   reg [5:0] next_a_out;
   reg [5:0] next_a_oen;
   reg [5:0] next_b_out;
   reg [5:0] next_b_oen;
   reg [1:0] next_txd;
   reg [1:0] next_rxs;
   reg [1:0] next_tfs;
   reg [1:0] next_rfs;

   // one port worth of routing, called twice
   task spbc_route;
      input  [`SPBC_CC_WIDTH-1:0] cc;
      input  [`SPBC_GP_WIDTH-1:0] gp;
      input                       bclk;
      input                       irise;
      input                       ifall;
      input  [5:0]                cur;
      input  [5:0]                prv;
      output [5:0]                pout;
      output [5:0]                poen;
      output                      txd;
      output                      rxs;
      output                      tfs;
      output                      rfs;
      reg                         syn;
      reg                         tx_int;
      reg                         rx_int;
      reg                         tx_r;
      reg                         tx_f;
      reg                         rx_f;
      reg [5:0]                   used;
      begin
         syn = cc[`SPBC_CC_SYN];
         // R08 async: clock dir and ctrl0 dir select per clock
         // R09 sync: ctrl0 dir ignored, clock dir selects both
         tx_int = cc[`SPBC_CC_CLOCK_PIN_DIRECTION];
         rx_int = syn ? cc[`SPBC_CC_CLOCK_PIN_DIRECTION] : cc[`SPBC_CC_SCD_LSB];
         // R06 internal clocks drive pins, external come in
         // R01 rx clock is its own pin in async, shared in sync
         tx_r = tx_int ? irise : (cur[3] & ~prv[3]);
         tx_f = tx_int ? ifall : (~cur[3] & prv[3]);
         if (syn) begin
            // R03 shared clock on clock pin
            rx_f = tx_f;
         end else begin
            // R02 receive clock on ctrl0
            rx_f = rx_int ? ifall : (~cur[0] & prv[0]);
         end
         // R13 R14 drive edge from polarity, sample on falling
         txd = spbc_drive_edge(cc[`SPBC_CC_CKP], tx_r, tx_f);
         rxs = rx_f;
         // R02 R03 frame syncs: ctrl2 tx, ctrl1 rx async; ctrl2 both sync
         tfs = cur[2] & ~prv[2];
         rfs = syn ? (cur[2] & ~prv[2]) : (cur[1] & ~prv[1]);
         // R04 direction: oe_n low when driving
         pout = gp[5:0];
         // no data shifting here, so the data pins stay plain gpio
         poen = ~gp[11:6];
         used = {2'b11, 1'b1, 1'b1, ~syn, ~syn | rx_int};
         used[0] = ~syn;
         // R05 unused pins fall back to gpio
         pout[3] = tx_int ? bclk : gp[3];
         poen[3] = tx_int ? 1'b0 : ~(gp[9] & ~used[3]);
         if (!syn && rx_int) begin
            pout[0] = bclk;
            poen[0] = 1'b0;
         end else if (!syn) begin
            poen[0] = 1'b1;
         end else begin
            poen[0] = ~cc[`SPBC_CC_SCD_LSB];
         end
         // rx sync or serial flag: both follow the ctrl direction bit
         poen[1] = ~cc[`SPBC_CC_SCD_LSB + 1];
         poen[2] = ~cc[`SPBC_CC_SCD_MSB];
      end
   endtask

   always @* begin
      spbc_route(audio_control_c, audio_gpio, a_bclk, a_rise, a_fall,
                 a_s2, a_s3, next_a_out, next_a_oen,
                 next_txd[0], next_rxs[0], next_tfs[0], next_rfs[0]);
      spbc_route(baseband_control_c, baseband_gpio, b_bclk, b_rise,
                 b_fall, b_s2, b_s3, next_b_out, next_b_oen,
                 next_txd[1], next_rxs[1], next_tfs[1], next_rfs[1]);
   end

   // ------------------------------------------------------------------------
   // frame length in bits for the shift logic
   // ------------------------------------------------------------------------
   // R17 R18 word length times (slots)
   wire [4:0] a_wl = spbc_wl_bits(audio_control_a[`SPBC_CA_WL_MSB:
                                                  `SPBC_CA_WL_LSB]);
   wire [5:0] a_dc = {1'b0, audio_control_a[`SPBC_CA_DC_MSB:
                                             `SPBC_CA_DC_LSB]} + 6'h01;
   wire [10:0] a_fb = a_wl * a_dc;

   // ------------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         audio_pins_o         <= 6'h00;
         audio_pins_oe_n_o    <= 6'h3f;
         baseband_pins_o      <= 6'h00;
         baseband_pins_oe_n_o <= 6'h3f;
         tx_drive_o           <= 2'h0;
         rx_sample_o          <= 2'h0;
         tx_sync_edge_o       <= 2'h0;
         rx_sync_edge_o       <= 2'h0;
         frame_bits_o         <= 10'h000;
      end else begin
         audio_pins_o         <= next_a_out;
         audio_pins_oe_n_o    <= next_a_oen;
         baseband_pins_o      <= next_b_out;
         baseband_pins_oe_n_o <= next_b_oen;
         tx_drive_o           <= next_txd;
         rx_sample_o          <= next_rxs;
         tx_sync_edge_o       <= next_tfs;
         rx_sync_edge_o       <= next_rfs;
         frame_bits_o         <= a_fb[9:0];
      end
   end

   // ------------------------------------------------------------------------
   // wishbone slave: one wait state, ack dropped the cycle after
   // ------------------------------------------------------------------------
   wire req = cyc_i & stb_i & ~ack_o;
   wire [7:0] off = adr_i[7:0];

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o              <= 1'b0;
         dat_o              <= 32'h0000_0000;
         audio_control_a    <= `SPBC_CA_RESET;
         audio_control_c    <= `SPBC_CC_RESET;
         baseband_control_a <= `SPBC_CA_RESET;
         baseband_control_c <= `SPBC_CC_RESET;
         audio_gpio         <= `SPBC_GP_RESET;
         baseband_gpio      <= `SPBC_GP_RESET;
      end else begin
         ack_o <= req;
         if (req && we_i) begin
            case (off)
               `SPBC_AUDIO_CONTROL_A:
                  audio_control_a <= dat_i[15:0];
               `SPBC_AUDIO_CONTROL_C:
                  audio_control_c <= dat_i[7:0];
               `SPBC_BASEBAND_CONTROL_A:
                  baseband_control_a <= dat_i[15:0];
               `SPBC_BASEBAND_CONTROL_C:
                  baseband_control_c <= dat_i[7:0];
               `SPBC_AUDIO_GPIO_OUT:
                  audio_gpio <= dat_i[11:0];
               `SPBC_BASEBAND_GPIO_OUT:
                  baseband_gpio <= dat_i[11:0];
               default: ;
            endcase
         end
         if (req) begin
            case (off)
               `SPBC_AUDIO_CONTROL_A:
                  dat_o <= {16'h0000, audio_control_a};
               `SPBC_AUDIO_CONTROL_C:
                  dat_o <= {24'h000000, audio_control_c};
               `SPBC_BASEBAND_CONTROL_A:
                  dat_o <= {16'h0000, baseband_control_a};
               `SPBC_BASEBAND_CONTROL_C:
                  dat_o <= {24'h000000, baseband_control_c};
               `SPBC_AUDIO_GPIO_OUT:
                  dat_o <= {20'h00000, audio_gpio};
               `SPBC_BASEBAND_GPIO_OUT:
                  dat_o <= {20'h00000, baseband_gpio};
               // live pin levels and internal clocks
               `SPBC_STATUS:
                  dat_o <= {16'h0000, 2'h0, b_bclk, a_bclk,
                            b_s2, a_s2[5:0]};
               default:
                  dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule // spbc_top

`default_nettype wire

// ===== tb/spbc_assertions.sv
// port-level checks for the serial port clock block
`timescale 1ns/1ps
`default_nettype none
module spbc_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        we_i,
   input wire logic [31:0] dat_o,
   input wire logic        ack_o,
   input wire logic [5:0]  audio_pins_o,
   input wire logic [5:0]  audio_pins_oe_n_o,
   input wire logic [5:0]  baseband_pins_oe_n_o,
   input wire logic [1:0]  tx_drive_o,
   input wire logic [1:0]  rx_sample_o,
   input wire logic [9:0]  frame_bits_o
);
   // --------------------------------------------------------------
   // bus, reset and pin checks
   // --------------------------------------------------------------
   // a write request seen on the bus, the only legal cause of config moves
   wire wr_req = cyc_i & stb_i & we_i;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack too long");
   a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
      else $error("ack without request");
   a_rdata_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
      else $error("read data moved");
   a_reset_idle: assert property ($fell(rst_i) |->
      audio_pins_oe_n_o == 6'h3f && baseband_pins_oe_n_o == 6'h3f
      && tx_drive_o == 2'h0 && !ack_o)
      else $error("pins not idle after reset");
   a_oe_cause: assert property ($changed(audio_pins_oe_n_o)
      || $changed(baseband_pins_oe_n_o) |-> $past(wr_req)
      || $past(wr_req, 2))
      else $error("direction moved without write");
   a_fbits_cause: assert property ($changed(frame_bits_o) |->
      $past(wr_req) || $past(wr_req, 2) || $past(rst_i)
      || $past(rst_i, 2))
      else $error("frame bits moved without write");
   a_bclk_spacing: assert property ($rose(audio_pins_o[3]) |=>
      (!$rose(audio_pins_o[3])) [*3])
      else $error("bit clock faster than a quarter");
   a_drive_gap: assert property (tx_drive_o[0] |=> !tx_drive_o[0])
      else $error("drive pulse doubled");
   a_sample_gap: assert property (rx_sample_o[0] |-> ##1 !rx_sample_o[0])
      else $error("sample pulse doubled");
endmodule // spbc_checker

bind spbc_top spbc_checker i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o),
   .audio_pins_o(audio_pins_o), .audio_pins_oe_n_o(audio_pins_oe_n_o),
   .baseband_pins_oe_n_o(baseband_pins_oe_n_o), .tx_drive_o(tx_drive_o),
   .rx_sample_o(rx_sample_o), .frame_bits_o(frame_bits_o)
);
`default_nettype wire

// ===== tb/spbc_codec_model.sv
// far-side codec model for one six-pin serial port
`timescale 1ns/1ps
`default_nettype none
module spbc_codec_model (
   input  wire logic       run_i,
   input  wire logic [5:0] dut_o_i,
   input  wire logic [5:0] dut_oe_n_i,
   output wire logic [5:0] pins_o
);
   logic   tclk, tfs, rclk, rfs, rxd, txd;
   integer tn, rn;
   // --------------------------------------------------------------
   // pin resolution and clock generation
   // --------------------------------------------------------------
   // a pin the port drives follows the port, else the codec level
   assign pins_o = (dut_oe_n_i & {txd, rxd, tclk, tfs, rfs, rclk})
                 | (~dut_oe_n_i & dut_o_i);
   // tx clock 40 ns, sync on ctrl2; stops low once run_i drops
   initial begin
      {tclk, tfs, rxd, txd, tn} = 0;
      #1.1;
      forever begin
         #20;
         if (run_i || tclk) begin
            tclk = ~tclk;
            tn = tn + 1;
            rxd = tn[1];
            txd = ~txd;
            tfs = (tn % 8) < 2;
         end
      end
   end
   // rx clock 60 ns on ctrl0, rx sync on ctrl1, own phase
   initial begin
      {rclk, rfs, rn} = 0;
      #1.3;
      forever begin
         #30;
         if (run_i || rclk) begin
            rclk = ~rclk;
            rn = rn + 1;
            rfs = (rn % 6) < 2;
         end
      end
   end
endmodule // spbc_codec_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench for the serial port clock block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, arun, mon, clock_edge_polarity, syn;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, q;
   logic [11:0] h0, h1, h2, h3;
   logic [8:0]  rt [0:4];
   wire  [31:0] dat_o;
   wire         ack_o;
   wire  [5:0]  apo, aoe, bpo, boe, apin, bpin;
   wire  [1:0]  txd, rxs, tfs, rfs;
   wire  [1:0]  bck = {bpo[3], apo[3]};
   wire  [9:0]  fbits;
   integer      mismatches, tests_run, i, c;
   // --------------------------------------------------------------
   // clock, design and codec models
   // --------------------------------------------------------------
   always #2.5 clk_i = ~clk_i;
   spbc_top i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .audio_pins_i(apin),
      .audio_pins_o(apo), .audio_pins_oe_n_o(aoe),
      .baseband_pins_i(bpin), .baseband_pins_o(bpo),
      .baseband_pins_oe_n_o(boe), .tx_drive_o(txd), .rx_sample_o(rxs),
      .tx_sync_edge_o(tfs), .rx_sync_edge_o(rfs), .frame_bits_o(fbits));
   spbc_codec_model i_acodec (.run_i(arun), .dut_o_i(apo),
      .dut_oe_n_i(aoe), .pins_o(apin));
   spbc_codec_model i_bcodec (.run_i(arun), .dut_o_i(bpo),
      .dut_oe_n_i(boe), .pins_o(bpin));
   // --------------------------------------------------------------
   // tasks
   // --------------------------------------------------------------
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // one classic cycle; held until ack is seen at a rising edge
   task bus(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk_i);
         {cyc_i, stb_i} <= 2'b11;
         we_i <= w;
         adr_i <= a;
         dat_i <= d;
         @(posedge clk_i);
         while (ack_o !== 1'b1) @(posedge clk_i);
         q = dat_o;
         {cyc_i, stb_i, we_i} <= 3'b000;
      end
   endtask
   task cfg(input p, input [31:0] ca, input [31:0] cc);
      begin
         bus(1'b1, {4'h0, p, 3'h0}, ca);
         bus(1'b1, {4'h0, p, 3'h4}, cc);
      end
   endtask
   // cycles spanned by k bit clock periods on the clock pin output
   task per(input p, input integer k);
      integer r;
      logic   l;
      begin
         {r, c} = 0;
         l = bck[p];
         while (r <= k && c < 20000) begin
            @(posedge clk_i);
            c = c + 1;
            if (bck[p] && !l) begin
               r = r + 1;
               if (r == 1) c = 0;
            end
            l = bck[p];
         end
      end
   endtask
   task final_report;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, mismatches);
         if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // --------------------------------------------------------------
   // external edge monitor: pulses trail pin edges by three cycles
   // --------------------------------------------------------------
   always @(posedge clk_i) {h3, h2, h1, h0} <= {h2, h1, h0, bpin, apin};
   always @(negedge clk_i) if (mon) begin
      chk(txd[0], clock_edge_polarity ? h3[3] & ~h2[3] : h2[3] & ~h3[3]);
      chk(rxs[0], syn ? h3[3] & ~h2[3] : h3[0] & ~h2[0]);
      chk(tfs[0], h2[2] & ~h3[2]);
      chk(rfs[0], syn ? h2[2] & ~h3[2] : h2[1] & ~h3[1]);
      chk({rxs[1], txd[1]}, {h3[6] & ~h2[6], h2[9] & ~h3[9]});
      chk({rfs[1], tfs[1]}, {h2[7] & ~h3[7], h2[8] & ~h3[8]});
   end
   initial begin
      #400000;
      mismatches = mismatches + 1;
      final_report;
   end
   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      {clk_i, cyc_i, stb_i, we_i, arun, mon, clock_edge_polarity, syn} = 0;
      {adr_i, dat_i, mismatches, tests_run} = 0;
      rst_i = 1'b1;
      sel_i = 4'hf;
      // bypass with modulus zero is never programmed: hazard for software
      rt = '{9'h101, 9'h103, 9'h000, 9'h002, 9'h0ff};
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (i = 0; i < 8; i++) if (i != 6) begin
         bus(1'b0, i * 4, 0);
         chk(q, 0);
      end
      chk({boe, aoe}, 12'hfff);
      bus(1'b1, 8'h1c, 32'hffffffff);
      bus(1'b0, 8'h1c, 0);
      chk(q, 0);
      bus(1'b1, 8'h00, 32'hfdff);
      bus(1'b0, 8'h00, 0);
      chk(q, 32'hfdff);
      repeat (3) @(posedge clk_i);
      chk(fbits, 512);
      for (i = 0; i < 3; i++) begin
         bus(1'b1, 8'h00, 32'h1800 | (i << 9));
         repeat (3) @(posedge clk_i);
         chk(fbits, (8 + 4 * i) * 4);
      end
      bus(1'b1, 8'h0c, 32'hff);
      bus(1'b0, 8'h0c, 0);
      chk(q, 32'hff);
      for (i = 0; i < 16; i++) begin
         bus(1'b1, 8'h04, {27'h0, i[0], i[3:0]});
         repeat (2) @(posedge clk_i);
         chk(aoe[3:0], {~i[3:0]});
      end
      bus(1'b1, 8'h10, 32'hc30);
      repeat (2) @(posedge clk_i);
      chk({aoe[5:4], apo[5:4]}, 4'h3);
      bus(1'b1, 8'h10, 32'hc10);
      bus(1'b1, 8'h14, 32'h820);
      bus(1'b0, 8'h10, 0);
      chk(q, 32'hc10);
      chk({aoe[5:4], apo[5:4], boe[5], bpo[5]}, 6'h05);
      bus(1'b1, 8'h10, 0);
      bus(1'b1, 8'h14, 0);
      // internal divider on both ports, first period after a change dropped
      for (i = 0; i < 10; i++) begin
         cfg(i / 5, rt[i % 5], 32'h08);
         per(i / 5, 1);
         per(i / 5, 2);
         chk(c, 4 * (rt[i % 5][8] ? 1 : 8) * (rt[i % 5][7:0] + 1));
      end
      // multiplier source with bypass and modulus three, then baseband
      cfg(1'b0, 32'h103, 32'h48);
      per(1'b0, 1);
      per(1'b0, 64);
      chk(c >= 523 && c <= 527, 1);
      cfg(1'b1, 32'h103, 32'h48);
      per(1'b1, 1);
      per(1'b1, 64);
      chk(c, 512);
      bus(1'b1, 8'h0c, 0);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, 8'h04, {26'h0, i[1], i[0], 4'h0});
         clock_edge_polarity <= i[1];
         syn <= i[0];
         repeat (4) @(posedge clk_i);
         {arun, mon} <= 2'b11;
         repeat (400) @(posedge clk_i);
         {arun, mon} <= 2'b00;
         repeat (40) @(posedge clk_i);
      end
      bus(1'b0, 8'h18, 0);
      chk(q[11:0], {bpin, apin});
      final_report;
   end
endmodule // testbench
`default_nettype wire
